/* hw/tpfe_pkg.sv */
/*
 * tpfe_pkg: constants for the two-phase fetch/execute sequencer.
 * assumes one system clock and a combinational program ROM outside the core.
 */
// Functional notes
// - instruction cycle is system clock divided by two
// - program counter updates in phase one
// - phase two latches ROM word into holding register
// - captured word executes next cycle, overlapping fetch
// - branch takes two cycles, prefetched word flushed
// - selected clock output toggles at half system rate
// - reset loads vector zero, interrupt vector one
package tpfe_pkg;
  localparam int PROG_CNT_W = 11;
  localparam int INSTR_W = 14;
  localparam logic [PROG_CNT_W-1:0] RESET_VECTOR = 11'h000;
  localparam logic [PROG_CNT_W-1:0] INTR_VECTOR = 11'h001;
  localparam logic [INSTR_W-1:0] INSTR_RESET = 14'h0000;
  localparam logic PHASE_RESET = 1'b0;
  typedef enum logic [0:0] {
    TPFE_PHASE_ONE = 1'b0,
    TPFE_PHASE_TWO = 1'b1
  } tpfe_phase_t;
endpackage : tpfe_pkg

/* hw/tpfe_fetch_if.sv */
/*
 * tpfe_fetch_if: carries the phase enables and fetched word between the
 * sequencer and its holding register. assumes a single clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
interface tpfe_fetch_if #(parameter int INSTR_W = 14);
  logic capture;
  logic clear;
  logic [INSTR_W-1:0] rom_word;
  logic [INSTR_W-1:0] held_word;
  logic held_valid;
  modport seq (output capture, output clear, output rom_word, input held_word,
    input held_valid);
  modport hold (input capture, input clear, input rom_word, output held_word,
    output held_valid);
endinterface : tpfe_fetch_if
`default_nettype wire

/* hw/tpfe_hold.sv */
/*
 * tpfe_hold: instruction holding register with a valid flag.
 * assumes capture and clear come from the sequencer in the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module tpfe_hold
  import tpfe_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RSTN,
  tpfe_fetch_if.hold fif
);
  logic [INSTR_W-1:0] word_r, word_nxt;
  logic valid_r, valid_nxt;

  always_comb begin
    word_nxt = word_r;
    valid_nxt = valid_r;
    if (fif.clear) begin
      valid_nxt = 1'b0; // flushed word never executes
    end else if (fif.capture) begin
      word_nxt = fif.rom_word;
      valid_nxt = 1'b1;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      word_r <= INSTR_RESET;
      valid_r <= 1'b0;
    end else begin
      word_r <= word_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign fif.held_word = word_r;
  assign fif.held_valid = valid_r;

  a_reset_empty: assert property (@(posedge CLOCK) !RSTN |=> !valid_r)
    else $error("holding register valid after reset");
endmodule : tpfe_hold
`default_nettype wire

/* hw/tpfe_core.sv */
/*
 * tpfe_core: two-phase fetch/execute sequencer of a small 8-bit core.
 * assumes the program ROM returns the word for ROM_ADDR combinationally on
 * ROM_DATA during phase two, and that the execute unit reports branches.
 */
`timescale 1ns/1ps
`default_nettype none
module tpfe_core
  import tpfe_pkg::*;
#(
  parameter int ADDR_W = PROG_CNT_W,
  parameter int WORD_W = INSTR_W
)(
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic [tpfe_pkg::INSTR_W-1:0] ROM_DATA,
  input wire logic BRANCH_TAKE,
  input wire logic [tpfe_pkg::PROG_CNT_W-1:0] BRANCH_TARGET,
  input wire logic INTR_ACCEPT,
  input wire logic CLKOUT_SEL,
  output logic [tpfe_pkg::PROG_CNT_W-1:0] ROM_ADDR,
  output logic PHASE_ONE,
  output logic PHASE_TWO,
  output logic [tpfe_pkg::INSTR_W-1:0] EXEC_WORD,
  output logic EXEC_VALID,
  output logic INSTR_CLOCK_OUT
);
  // other widths would need a matching rom and holding register as well
  if (ADDR_W != PROG_CNT_W || WORD_W != INSTR_W) begin : g_bad_width
    $error("tpfe_core: widths must match the package");
  end


  tpfe_fetch_if #(.INSTR_W(INSTR_W)) fif ();

  tpfe_phase_t phase_r, phase_nxt;
  logic [PROG_CNT_W-1:0] program_counter_r, program_counter_nxt;
  logic [PROG_CNT_W-1:0] addr_r, addr_nxt;
  logic flush_r, flush_nxt;
  logic clk_out_r, clk_out_nxt;
  logic phase_one, phase_two;
  logic branch_event;

  assign phase_one = (phase_r == TPFE_PHASE_ONE);
  assign phase_two = (phase_r == TPFE_PHASE_TWO);
  // branches are sampled only while a valid word executes, at its phase one
  assign branch_event = phase_one && fif.held_valid && BRANCH_TAKE;

  // phase divider
  always_comb begin
    case (phase_r)
      TPFE_PHASE_ONE: phase_nxt = TPFE_PHASE_TWO;
      TPFE_PHASE_TWO: phase_nxt = TPFE_PHASE_ONE;
      default: phase_nxt = TPFE_PHASE_ONE;
    endcase
  end

  // program counter: moves only in phase one
  // an interrupt wins over a branch on the same edge; the count wraps silently
  always_comb begin
    program_counter_nxt = program_counter_r;
    addr_nxt = addr_r;
    if (phase_one) begin
      if (INTR_ACCEPT) begin
        program_counter_nxt = INTR_VECTOR;
      end else if (branch_event) begin
        program_counter_nxt = BRANCH_TARGET;
      end else begin
        program_counter_nxt = program_counter_r + 1'b1;
      end
      addr_nxt = program_counter_r; // word fetched this cycle
    end
  end

  // a taken branch or interrupt flushes the word fetched in parallel
  always_comb begin
    flush_nxt = flush_r;
    if (phase_one) begin
      flush_nxt = INTR_ACCEPT || branch_event;
    end
  end

  // instruction clock: low in phase one, high in phase two
  always_comb begin
    clk_out_nxt = CLKOUT_SEL && (phase_nxt == TPFE_PHASE_TWO);
  end

  // the holding register loads at the end of phase two
  assign fif.capture = phase_two;
  assign fif.clear = phase_two && flush_r;
  assign fif.rom_word = ROM_DATA;

  tpfe_hold u_hold (
    .CLOCK(CLOCK),
    .RSTN(RSTN),
    .fif(fif)
  );

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      phase_r <= TPFE_PHASE_ONE;
      program_counter_r <= RESET_VECTOR;
      addr_r <= RESET_VECTOR;
      flush_r <= 1'b0;
      clk_out_r <= PHASE_RESET;
    end else begin
      phase_r <= phase_nxt;
      program_counter_r <= program_counter_nxt;
      addr_r <= addr_nxt;
      flush_r <= flush_nxt;
      clk_out_r <= clk_out_nxt;
    end
  end

  // outputs from flip-flops; PHASE_ONE and PHASE_TWO are decoded from phase_r
  always_comb begin
    ROM_ADDR = addr_r;
    PHASE_ONE = phase_one;
    PHASE_TWO = phase_two;
    EXEC_WORD = fif.held_word; // executes across the following cycle
    EXEC_VALID = fif.held_valid;
    INSTR_CLOCK_OUT = clk_out_r;
  end

  // antecedents sample RSTN too: disable iff reads the live value, so an
  // attempt could otherwise start on the very edge that releases reset
  sequence s_live_one;
    RSTN && phase_one;
  endsequence

  sequence s_live_two;
    RSTN && phase_two;
  endsequence

  sequence s_plain_step;
    RSTN && phase_one && !INTR_ACCEPT && !(fif.held_valid && BRANCH_TAKE);
  endsequence

  sequence s_branch_seen;
    RSTN && phase_one && fif.held_valid && BRANCH_TAKE && !INTR_ACCEPT;
  endsequence

  sequence s_intr_seen;
    RSTN && phase_one && INTR_ACCEPT;
  endsequence

  // the prefetched word is dropped: nothing executes in the next phase one
  sequence s_flush_slot;
    ##1 (!EXEC_VALID && phase_one);
  endsequence

  a_phase_alt: assert property (@(posedge CLOCK) disable iff (!RSTN)
    s_live_one |=> phase_two ##1 phase_one)
    else $error("phases do not alternate");
  a_phase_back: assert property (@(posedge CLOCK) disable iff (!RSTN)
    s_live_two |=> phase_one)
    else $error("phase two not followed by phase one");
  a_reset_phase: assert property (@(posedge CLOCK)
    !RSTN |=> phase_one && !INSTR_CLOCK_OUT)
    else $error("reset did not return to phase one");

  a_count_steps: assert property (@(posedge CLOCK) disable iff (!RSTN)
    s_plain_step |=> program_counter_r == $past(program_counter_r) + 11'h001)
    else $error("program counter did not step");
  a_count_hold: assert property (@(posedge CLOCK) disable iff (!RSTN)
    s_live_two |=> $stable(program_counter_r))
    else $error("program counter moved in phase two");
  a_addr_fetch: assert property (@(posedge CLOCK) disable iff (!RSTN)
    s_live_one |=> ROM_ADDR == $past(program_counter_r))
    else $error("fetch address is not the counter value");

  a_addr_hold: assert property (@(posedge CLOCK) disable iff (!RSTN)
    s_live_two |=> $stable(ROM_ADDR))
    else $error("fetch address moved in phase two");
  a_capture_word: assert property (@(posedge CLOCK) disable iff (!RSTN)
    s_live_two ##0 !flush_r |=> EXEC_WORD == $past(ROM_DATA))
    else $error("fetched word not captured");

  a_exec_stream: assert property (@(posedge CLOCK) disable iff (!RSTN)
    s_live_two ##0 !flush_r |=> EXEC_VALID [*2])
    else $error("captured word not executed for a full cycle");
  a_exec_hold: assert property (@(posedge CLOCK) disable iff (!RSTN)
    s_live_one |=> $stable(EXEC_WORD) && $stable(EXEC_VALID))
    else $error("executing word changed in mid cycle");

  a_branch_flush: assert property (@(posedge CLOCK) disable iff (!RSTN)
    s_branch_seen |=> s_flush_slot)
    else $error("branch did not flush prefetched word");
  a_branch_resume: assert property (@(posedge CLOCK) disable iff (!RSTN)
    s_branch_seen ##2 !INTR_ACCEPT |=> ##1 EXEC_VALID)
    else $error("branch target word not executed");
  a_branch_jump: assert property (@(posedge CLOCK) disable iff (!RSTN)
    s_branch_seen |=> program_counter_r == $past(BRANCH_TARGET))
    else $error("program counter did not take the branch target");
  a_branch_target: assert property (@(posedge CLOCK) disable iff (!RSTN)
    s_branch_seen |=> ##2 ROM_ADDR == $past(BRANCH_TARGET, 3))
    else $error("branch target not fetched");
  a_branch_refused: assert property (@(posedge CLOCK) disable iff (!RSTN)
    s_live_one ##0 (!EXEC_VALID && BRANCH_TAKE && !INTR_ACCEPT) |=>
    program_counter_r == $past(program_counter_r) + 11'h001)
    else $error("branch taken from an empty holding register");

  a_clkout_half: assert property (@(posedge CLOCK) disable iff (!RSTN)
    s_live_one ##0 CLKOUT_SEL |=> INSTR_CLOCK_OUT ##1 !INSTR_CLOCK_OUT)
    else $error("instruction clock output wrong");
  a_clkout_off: assert property (@(posedge CLOCK) disable iff (!RSTN)
    s_live_one ##0 !CLKOUT_SEL |=> !INSTR_CLOCK_OUT)
    else $error("instruction clock output high while not selected");

  a_intr_vector: assert property (@(posedge CLOCK) disable iff (!RSTN)
    s_intr_seen |=> program_counter_r == INTR_VECTOR)
    else $error("interrupt vector not loaded");
  a_intr_flush: assert property (@(posedge CLOCK) disable iff (!RSTN)
    s_intr_seen |=> s_flush_slot)
    else $error("interrupt did not flush prefetched word");
  a_reset_vector: assert property (@(posedge CLOCK)
    !RSTN |=> program_counter_r == RESET_VECTOR && !EXEC_VALID)
    else $error("reset state wrong");
  a_first_fetch: assert property (@(posedge CLOCK)
    !RSTN ##1 (RSTN && !INTR_ACCEPT) |=> ROM_ADDR == RESET_VECTOR ##1 EXEC_VALID)
    else $error("first word after reset not from the reset vector");
endmodule : tpfe_core
`default_nettype wire

/* test/tpfe_rom_model.sv */
/* tpfe_rom_model: program rom beside the core, one fixed word per address.
   assumes the core reads it combinationally while the address stands. */
`timescale 1ns/1ps
`default_nettype none
module tpfe_rom_model
  import tpfe_pkg::*;
(
  input wire logic [tpfe_pkg::PROG_CNT_W-1:0] ADDR,
  output logic [tpfe_pkg::INSTR_W-1:0] DATA
);
  // neighbouring addresses give different words, so a wrong fetch shows up
  assign DATA = INSTR_W'(ADDR * 5) ^ 14'h2C3;
endmodule : tpfe_rom_model
`default_nettype wire

/* test/tpfe_core_tb.sv */
/* tpfe_core_tb: random branches, interrupts and clock select against a
   cycle model of the sequencer. assumes tpfe_rom_model as program rom. */
`timescale 1ns/1ps
`default_nettype none
module tpfe_core_tb;
  import tpfe_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic br = 1'b0;
  logic ia = 1'b0;
  logic sel = 1'b0;
  logic [PROG_CNT_W-1:0] tgt = 11'h000;
  logic [INSTR_W-1:0] rd;
  logic [PROG_CNT_W-1:0] addr;
  logic [INSTR_W-1:0] ew;
  logic ph1, ph2, ev, ico;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  int m_pc, m_addr, m_ph, m_fl, m_v, m_ico, m_w;
  always #10 clock = ~clock;
  tpfe_rom_model rom_u (.ADDR(addr), .DATA(rd));
  tpfe_core dut_u (.CLOCK(clock), .RSTN(rstn), .ROM_DATA(rd), .BRANCH_TAKE(br),
    .BRANCH_TARGET(tgt), .INTR_ACCEPT(ia), .CLKOUT_SEL(sel), .ROM_ADDR(addr),
    .PHASE_ONE(ph1), .PHASE_TWO(ph2), .EXEC_WORD(ew), .EXEC_VALID(ev),
    .INSTR_CLOCK_OUT(ico));
  task automatic close_out;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  task automatic chk_v(input logic [INSTR_W-1:0] got, input logic [INSTR_W-1:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_v
  task automatic chk_f(input logic got, input logic exp);
    chk_v({13'h0000, got}, {13'h0000, exp});
  endtask : chk_f
  // the ceiling sits well above the two runs of 1500 cycles each
  always @(posedge clock) begin
    if (cyc == 4000) begin
      fails++;
      close_out();
    end
  end
  // model and stimulus share one process so the model sees pre-edge inputs
  always @(posedge clock) begin
    if (cyc == 0)
      void'($urandom(32'h29E7));
    cyc <= cyc + 1;
    if (!rstn) begin
      m_pc = 0;
      m_addr = 0;
      m_ph = 0;
      m_fl = 0;
      m_v = 0;
      m_ico = 0;
      m_w = 0;
    end else if (m_ph == 0) begin
      m_addr = m_pc;
      m_pc = (m_pc + 1) & 32'h7FF;
      m_fl = 0;
      if (ia) begin
        m_pc = 1;
        m_fl = 1;
      end else if (br && m_v != 0) begin
        m_pc = tgt;
        m_fl = 1;
      end
      m_ph = 1;
      m_ico = sel;
    end else begin
      m_w = ((m_addr * 5) ^ 32'h2C3) & 32'h3FFF;
      m_v = !m_fl;
      m_ph = 0;
      m_ico = 0;
    end
    // branch requests land in both phases, so phase-two ones must be ignored
    br <= ($urandom % 4) == 0;
    tgt <= PROG_CNT_W'($urandom);
    ia <= ($urandom % 16) == 0;
    if (m_ph == 0)
      sel <= 1'($urandom);
  end
  always @(negedge clock) begin
    if (cyc > 1) begin
      chk_f(ph1, m_ph == 0);
      chk_f(ph2, m_ph == 1);
      chk_v({3'h0, addr}, INSTR_W'(m_addr));
      chk_f(ev, m_v != 0);
      if (m_v != 0)
        chk_v(ew, INSTR_W'(m_w));
      chk_f(ico, m_ico != 0);
    end
  end
  initial begin
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    repeat (1500) @(posedge clock);
    rstn <= 1'b0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    repeat (1500) @(posedge clock);
    close_out();
  end
endmodule : tpfe_core_tb
`default_nettype wire
